/* File: ppsh_pkg.sv */
// shared constants and types for the position select / start handshake
package ppsh_pkg;

	// =====================================================================
	// pin widths and patterns
	localparam int          SEL_W        = 8;
	localparam logic [1:0]  PAT_FOUR     = 2'h0;
	localparam logic [1:0]  PAT_EIGHT    = 2'h2;
	localparam logic [7:0]  SEL_MASK_4   = 8'h0F;
	localparam logic [7:0]  SEL_MASK_8   = 8'hFF;

	// =====================================================================
	// timing
	localparam int          CLK_KHZ        = 250000;
	localparam int          SEL_SETTLE_MS  = 6;
	localparam int          SEL_SETTLE_CYC = SEL_SETTLE_MS * CLK_KHZ;
	localparam int          FILT_CYC       = 8;
	localparam logic [7:0]  STROBE_MIN_CYC = 8'h40;

	// =====================================================================
	// controller register map (byte addresses)
	localparam logic [7:0]  REG_CTRL       = 8'h00;
	localparam logic [7:0]  REG_STATUS     = 8'h04;
	localparam logic [7:0]  REG_SETTLE     = 8'h08;
	localparam logic [7:0]  REG_HOME_ENTRY = 8'h0C;
	localparam int          CTRL_GO_BIT    = 8;
	localparam int          CTRL_PAT_LSB   = 12;
	localparam int          STAT_REFUSE    = 3;
	localparam logic [7:0]  HOME_ENTRY_RST = 8'h00;
	localparam logic [1:0]  PAT_RST        = 2'h0;

	// =====================================================================
	// state encodings
	typedef enum logic [2:0] {
		DS_IDLE    = 3'h0,
		DS_HOMING  = 3'h1,
		DS_MOVING  = 3'h2,
		DS_REACHED = 3'h3,
		DS_DONE    = 3'h4
	} ppsh_dstate_t;

	typedef enum logic [2:0] {
		HS_IDLE    = 3'h0,
		HS_SETTLE  = 3'h1,
		HS_STROBE  = 3'h2,
		HS_RELEASE = 3'h3
	} ppsh_hstate_t;

endpackage : ppsh_pkg

/* File: ppsh_if.sv */
// parallel_io lines between the controller and the actuator
`timescale 1ns/1ps
interface ppsh_if;
	logic [7:0] pos_sel;
	logic       move_start_strobe;
	logic       move_done_flag;
	logic       homed_flag;

	modport device (
		input  pos_sel,
		input  move_start_strobe,
		output move_done_flag,
		output homed_flag
	);

	modport host (
		output pos_sel,
		output move_start_strobe,
		input  move_done_flag,
		input  homed_flag
	);
endinterface : ppsh_if

/* File: ppsh_sync_filter.sv */
// two-flop synchroniser followed by a stability filter
`timescale 1ns/1ps
module ppsh_sync_filter
	import ppsh_pkg::*;
#(
	parameter int W    = 1,
	parameter int FILT = FILT_CYC
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// asynchronous input and filtered copy
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] q;
		logic [15:0]  cnt;
	} ppsh_sf_t;

	ppsh_sf_t r_reg;
	ppsh_sf_t r_next;

	// =====================================================================
	// filter: the input must differ from the output FILT cycles in a row before it is passed on
	always_comb begin
		r_next    = r_reg;
		r_next.s1 = d;
		r_next.s2 = r_reg.s1;
		if (r_reg.s2 == r_reg.q) begin
			r_next.cnt = 16'h0000;
		end else if (r_reg.cnt >= 16'(FILT - 1)) begin
			r_next.q   = r_reg.s2;
			r_next.cnt = 16'h0000;
		end else begin
			r_next.cnt = r_reg.cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign q = r_reg.q;

endmodule : ppsh_sync_filter

/* File: ppsh_device.sv */
// actuator end of the position select / start handshake
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps

module ppsh_device
	import ppsh_pkg::*;
#(
	parameter int FILT = FILT_CYC
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// parallel_io lines
	ppsh_if.device          parallel_io,
	// configuration
	input  wire logic [1:0] pattern,
	input  wire logic       done_inp_mode,
	// drive status
	input  wire logic       servo_on,
	input  wire logic       home_lost,
	// motion engine
	output logic            move_req,
	output logic            home_req,
	output logic [7:0]      move_entry,
	input  wire logic       home_ok,
	input  wire logic       in_width,
	// state view
	output logic            busy
);

	typedef struct packed {
		ppsh_dstate_t st;
		logic         strb_d;
		logic         done;
		logic         homed;
		logic         move_req;
		logic         home_req;
		logic [7:0]   entry;
		logic         busy;
		logic [2:0]   cfg_s1;
		logic [2:0]   cfg_s2;
	} ppsh_dev_t;

	ppsh_dev_t r_reg;
	ppsh_dev_t r_next;

	logic [8:0] filt_q;
	logic [7:0] sel_f;
	logic       strb_f;
	logic       strb_rise;
	logic [1:0] pat_s;
	logic       mode_s;
	logic       start_ok;
	logic       home_set;

	// =====================================================================
	// input conditioning
	// select and strobe share one filter so both carry the same delay
	// latency from pin to edge is about FILT plus two cycles
	ppsh_sync_filter #(
		.W    (9),
		.FILT (FILT)
	) u_in_filt (
		.clk (clk),
		.rst (rst),
		.d   ({parallel_io.move_start_strobe, parallel_io.pos_sel}),
		.q   (filt_q)
	);

	assign strb_f    = filt_q[8];
	assign strb_rise = strb_f & ~r_reg.strb_d;

	// the four-line pattern ignores the upper lines
	function automatic logic [7:0] sel_masked(input logic [1:0] pat, input logic [7:0] raw);
		sel_masked = (pat == PAT_EIGHT) ? (raw & SEL_MASK_8) : (raw & SEL_MASK_4);
	endfunction : sel_masked

	assign sel_f = sel_masked(pat_s, filt_q[7:0]);

	// =====================================================================
	// configuration pins pass two flops, like the parallel_io lines
	assign pat_s  = r_reg.cfg_s2[1:0];
	assign mode_s = r_reg.cfg_s2[2];

	// =====================================================================
	// start and home-reference decode
	// a strobe edge during homing is dropped, not queued
	assign start_ok = strb_rise && (r_reg.st != DS_HOMING);
	assign home_set = (r_reg.st == DS_HOMING) && home_ok;

	function automatic logic active_state(input ppsh_dstate_t s);
		active_state = (s == DS_HOMING) || (s == DS_MOVING) || (s == DS_REACHED);
	endfunction : active_state

	// =====================================================================
	// handshake sequencer
	always_comb begin
		r_next          = r_reg;
		r_next.strb_d   = strb_f;
		r_next.move_req = 1'b0;
		r_next.home_req = 1'b0;
		r_next.cfg_s1   = {done_inp_mode, pattern};
		r_next.cfg_s2   = r_reg.cfg_s1;

		case (r_reg.st)
			DS_IDLE: begin
				r_next.done = 1'b0;
			end
			DS_HOMING: begin
				r_next.done = 1'b0;
				if (home_ok) begin
					r_next.homed    = 1'b1;
					r_next.entry    = sel_f;
					r_next.move_req = 1'b1;
					r_next.st       = DS_MOVING;
				end
			end
			DS_MOVING: begin
				// the motion engine keeps running to target past this point
				if (in_width) begin
					r_next.st = DS_REACHED;
				end
			end
			DS_REACHED: begin
				if (!strb_f) begin
					r_next.done = 1'b1;
					r_next.st   = DS_DONE;
				end
			end
			DS_DONE: begin
				// sticky unless the in-position mode is chosen
				if (mode_s) begin
					r_next.done = in_width;
				end else begin
					r_next.done = 1'b1;
				end
			end
			default: begin
				r_next.st   = DS_IDLE;
				r_next.done = 1'b0;
			end
		endcase

		// a later start supersedes the current move; homing runs to its end
		if (start_ok) begin
			r_next.done  = 1'b0;
			r_next.entry = sel_f;
			if (!r_reg.homed) begin
				r_next.home_req = 1'b1;
				r_next.st       = DS_HOMING;
			end else begin
				r_next.move_req = 1'b1;
				r_next.st       = DS_MOVING;
			end
		end

		// servo-off clears done but lets a move run on
		if (!servo_on) begin
			r_next.done = 1'b0;
			if (r_reg.st == DS_DONE) begin
				r_next.st = DS_IDLE;
			end
		end

		// a reference found in the same cycle wins over its loss
		if (home_lost && !home_set) begin
			r_next.homed = 1'b0;
		end

		r_next.busy = active_state(r_next.st);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r_reg <= '{st: DS_IDLE, default: '0};
		end else begin
			r_reg <= r_next;
		end
	end

	// =====================================================================
	// outputs, all from flops
	assign parallel_io.move_done_flag = r_reg.done;
	assign parallel_io.homed_flag     = r_reg.homed;
	assign move_req           = r_reg.move_req;
	assign home_req           = r_reg.home_req;
	assign move_entry         = r_reg.entry;
	assign busy               = r_reg.busy;

endmodule : ppsh_device

/* File: ppsh_host.sv */
// controller end: APB command registers driving the parallel_io lines
`timescale 1ns/1ps
module ppsh_host
	import ppsh_pkg::*;
#(
	parameter int SETTLE_CYC = SEL_SETTLE_CYC,
	parameter int FILT       = 2
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// parallel_io lines
	ppsh_if.host             parallel_io
);

	typedef struct packed {
		ppsh_hstate_t st;
		logic [7:0]   sel;
		logic         strobe;
		logic [31:0]  cnt;
		logic [31:0]  settle;
		logic [7:0]   entry;
		logic [7:0]   home_entry;
		logic [1:0]   pat;
		logic         refused;
		logic [31:0]  prdata;
		logic         pready;
		logic         pslverr;
	} ppsh_host_t;

	ppsh_host_t r_reg;
	ppsh_host_t r_next;

	logic [1:0] in_f;
	logic       done_s;
	logic       homed_s;
	logic       wr;
	logic       go;

	ppsh_sync_filter #(
		.W    (2),
		.FILT (FILT)
	) u_in_sync (
		.clk (clk),
		.rst (rst),
		.d   ({parallel_io.homed_flag, parallel_io.move_done_flag}),
		.q   (in_f)
	);

	assign done_s  = in_f[0];
	assign homed_s = in_f[1];
	assign wr      = psel & penable & r_reg.pready & pwrite;
	assign go      = wr && paddr == REG_CTRL && pwdata[CTRL_GO_BIT];

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_SETTLE) ||
			(a == REG_HOME_ENTRY);
	endfunction : mapped

	// =====================================================================
	// register access and handshake sequencer
	always_comb begin
		r_next         = r_reg;
		r_next.pready  = psel & ~penable;
		r_next.pslverr = psel & ~penable & ~mapped(paddr);
		r_next.prdata  = 32'h0000_0000;
		if (psel && !penable) begin
			case (paddr)
				REG_CTRL:       r_next.prdata = {16'h0000, 2'h0, r_reg.pat, 4'h0, r_reg.entry};
				REG_STATUS:     r_next.prdata = {25'h0, r_reg.st, r_reg.refused, homed_s,
					done_s, r_reg.st != HS_IDLE};
				REG_SETTLE:     r_next.prdata = r_reg.settle;
				REG_HOME_ENTRY: r_next.prdata = {24'h0, r_reg.home_entry};
				default:        r_next.prdata = 32'h0000_0000;
			endcase
		end
		if (wr) begin
			case (paddr)
				REG_CTRL: begin
					r_next.entry = pwdata[7:0];
					r_next.pat   = pwdata[CTRL_PAT_LSB+1:CTRL_PAT_LSB];
				end
				REG_STATUS:     if (pwdata[STAT_REFUSE]) r_next.refused = 1'b0;
				REG_SETTLE:     r_next.settle = pwdata;
				REG_HOME_ENTRY: r_next.home_entry = pwdata[7:0];
				default:        r_next.settle = r_reg.settle;
			endcase
		end

		case (r_reg.st)
			HS_IDLE: begin
				if (go) begin
					// unhomed eight-line axis may only start the entry held in home_entry
					if (pwdata[CTRL_PAT_LSB+1:CTRL_PAT_LSB] == PAT_EIGHT && !homed_s &&
						pwdata[7:0] != r_reg.home_entry) begin
						r_next.refused = 1'b1;
					end else begin
						r_next.sel = (pwdata[CTRL_PAT_LSB+1:CTRL_PAT_LSB] == PAT_EIGHT) ?
							pwdata[7:0] : (pwdata[7:0] & SEL_MASK_4);
						r_next.cnt = 32'h0000_0000;
						r_next.st  = HS_SETTLE;
					end
				end
			end
			HS_SETTLE: begin
				r_next.cnt = r_reg.cnt + 32'h0000_0001;
				if (r_reg.cnt + 32'h0000_0001 >= r_reg.settle) begin
					r_next.strobe = 1'b1;
					r_next.cnt    = 32'h0000_0000;
					r_next.st     = HS_STROBE;
				end
			end
			HS_STROBE: begin
				// minimum hold covers the far end's input filter delay
				if (r_reg.cnt[7:0] != STROBE_MIN_CYC) begin
					r_next.cnt = r_reg.cnt + 32'h0000_0001;
				end else if (!done_s) begin
					r_next.strobe = 1'b0;
					r_next.st     = HS_RELEASE;
				end
			end
			HS_RELEASE: begin
				if (done_s) begin
					r_next.st = HS_IDLE;
				end
			end
			default: begin
				r_next.strobe = 1'b0;
				r_next.st     = HS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r_reg <= '{st: HS_IDLE, settle: 32'(SETTLE_CYC), home_entry: HOME_ENTRY_RST,
				pat: PAT_RST, default: '0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign prdata                = r_reg.prdata;
	assign pready                = r_reg.pready;
	assign pslverr               = r_reg.pslverr;
	assign parallel_io.pos_sel           = r_reg.sel;
	assign parallel_io.move_start_strobe = r_reg.strobe;

endmodule : ppsh_host

/* File: ppsh_monitor.sv */
// checker for the parallel_io handshake lines
`timescale 1ns/1ps
module ppsh_monitor
	import ppsh_pkg::*;
#(
	parameter int SETTLE = 50
) (
	// clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// parallel_io lines
	input wire logic [7:0] pos_sel,
	input wire logic       move_start_strobe,
	input wire logic       move_done_flag,
	input wire logic       homed_flag,
	// drive status
	input wire logic       home_lost
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// =================================================================
	// select stability counter
	logic [15:0] stab_reg;
	logic [7:0]  sel_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stab_reg <= 16'h0000;
			sel_reg  <= 8'h00;
		end else begin
			sel_reg  <= pos_sel;
			if (pos_sel != sel_reg)
				stab_reg <= 16'h0000;
			else if (stab_reg != 16'hFFFF)
				stab_reg <= stab_reg + 16'h0001;
		end
	end

	// =================================================================
	// assertions
	// margin of three covers the counter lagging the select lines
	a_settle_before_start: assert property ($rose(move_start_strobe) |-> stab_reg >= SETTLE - 3)
		else $error("strobe raised before select settled");
	a_sel_held_strobe: assert property (move_start_strobe |-> $stable(pos_sel))
		else $error("select changed under strobe");
	a_strobe_min_hold: assert property ($rose(move_start_strobe) |=> move_start_strobe [*8])
		else $error("strobe released too early");
	a_release_after_drop: assert property ($fell(move_start_strobe) |-> !move_done_flag)
		else $error("strobe released while done high");
	a_done_drops_start: assert property ($rose(move_start_strobe) |-> ##[1:16] !move_done_flag)
		else $error("done not dropped at start");
	a_done_low_strobe: assert property (move_start_strobe && $past(move_start_strobe, 16) |-> !move_done_flag)
		else $error("done high while strobe held");
	a_done_rise_release: assert property ($rose(move_done_flag) |-> !move_start_strobe)
		else $error("done rose with strobe high");
	a_done_needs_homed: assert property ($rose(move_done_flag) |-> homed_flag)
		else $error("done rose before homing");
	a_homed_kept: assert property ($fell(homed_flag) |-> $past(home_lost))
		else $error("homed flag lost");
endmodule : ppsh_monitor

/* File: tb_position_select_start_handshake.sv */
// testbench: controller and actuator ends joined over parallel_io
`timescale 1ns/1ps
module tb_position_select_start_handshake
	import ppsh_pkg::*;
;
	localparam int ST = 50;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr;
	logic [1:0]  pattern = 2'h2;
	logic        mode = 1'b0;
	logic        w_reg = 1'b0;
	logic        drop = 1'b0;
	logic        servo = 1'b1;
	logic        lost = 1'b0;
	logic        busy;
	logic        home_ok = 1'b0;
	logic        hm = 1'b0;
	logic        homed_seen = 1'b0;
	logic        in_width;
	logic        move_req, home_req;
	logic [7:0]  move_entry;
	int          mismatches = 0;
	int          compares = 0;
	int          cnt = 0;

	always #2 clk = ~clk;
	// a fresh move request hides the last arrival in the cycle it is issued
	assign in_width = w_reg & ~drop & ~move_req;

	// =================================================================
	// design ends and checker
	ppsh_if pif ();
	ppsh_host #(.SETTLE_CYC(ST)) i_ppsh_host (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .parallel_io(pif));
	ppsh_device i_ppsh_device (.clk(clk), .rst(rst), .parallel_io(pif), .pattern(pattern),
		.done_inp_mode(mode), .servo_on(servo), .home_lost(lost), .move_req(move_req),
		.home_req(home_req), .move_entry(move_entry), .home_ok(home_ok),
		.in_width(in_width), .busy(busy));
	ppsh_monitor #(.SETTLE(ST)) i_ppsh_monitor (.clk(clk), .rst(rst),
		.pos_sel(pif.pos_sel), .move_start_strobe(pif.move_start_strobe),
		.move_done_flag(pif.move_done_flag), .homed_flag(pif.homed_flag),
		.home_lost(lost));

	// motion engine: in_width cleared on every request so no stale arrival
	always @(posedge clk) begin
		home_ok <= 1'b0;
		if (home_req || move_req) begin
			w_reg <= 1'b0;
			hm    <= home_req;
			cnt   <= home_req ? 30 : 20;
			if (home_req)
				homed_seen <= 1'b1;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
			if (cnt == 1 && hm)
				home_ok <= 1'b1;
			if (cnt == 1 && !hm)
				w_reg <= 1'b1;
		end
	end

	// =================================================================
	// tasks
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task run(input logic [1:0] p, input logic [7:0] en);
		logic [31:0] r;
		logic        e;
		int          t;
		pattern <= p;
		apb(1'b1, REG_CTRL, (32'(p) << CTRL_PAT_LSB) | 32'h100 | 32'(en), r, e);
		for (t = 0; t < 3000 && pif.move_done_flag !== 1'b0; t++) @(posedge clk);
		chk("done_drop", 32'h0, 32'(pif.move_done_flag));
		for (t = 0; t < 3000 && (pif.move_done_flag !== 1'b1 || pif.move_start_strobe); t++)
			@(posedge clk);
		chk("done_rise", 32'h1, 32'(pif.move_done_flag));
		chk("busy_clear", 32'h0, 32'(busy));
		r = 32'h1;
		for (t = 0; t < 50 && r[0] !== 1'b0; t++)
			apb(1'b0, REG_STATUS, 32'h0, r, e);
		chk("host_idle", 32'h0, 32'(r[0]));
	endtask : run

	task s_regs;
		logic [31:0] r;
		logic        e;
		apb(1'b0, REG_SETTLE, 32'h0, r, e);
		chk("settle", 32'(ST), r);
		apb(1'b0, REG_HOME_ENTRY, 32'h0, r, e);
		chk("home_entry", 32'(HOME_ENTRY_RST), r);
		apb(1'b0, 8'h20, 32'h0, r, e);
		chk("unmapped_err", 32'h1, 32'(e));
		chk("unmapped_data", 32'h0, r);
	endtask : s_regs

	task s_home_first;
		logic [31:0] r;
		logic        e;
		apb(1'b1, REG_CTRL, 32'h2133, r, e);
		apb(1'b0, REG_STATUS, 32'h0, r, e);
		chk("refused", 32'h1, 32'(r[STAT_REFUSE]));
		apb(1'b1, REG_STATUS, 32'h8, r, e);
		apb(1'b0, REG_STATUS, 32'h0, r, e);
		chk("refuse_clr", 32'h0, 32'(r[STAT_REFUSE]));
		run(PAT_EIGHT, 8'h00);
		chk("home_req", 32'h1, 32'(homed_seen));
		chk("homed", 32'h1, 32'(pif.homed_flag));
		chk("entry_home", 32'h0, 32'(move_entry));
	endtask : s_home_first

	task s_positions;
		run(PAT_EIGHT, 8'hA5);
		chk("entry8", 32'hA5, 32'(move_entry));
		run(PAT_EIGHT, 8'hA5);
		chk("entry_same", 32'hA5, 32'(move_entry));
		run(PAT_FOUR, 8'hA5);
		chk("entry4", 32'h05, 32'(move_entry));
		chk("homed_kept", 32'h1, 32'(pif.homed_flag));
	endtask : s_positions

	task s_done_mode;
		@(posedge clk);
		drop <= 1'b1;
		repeat (4) @(posedge clk);
		chk("sticky", 32'h1, 32'(pif.move_done_flag));
		mode <= 1'b1;
		repeat (6) @(posedge clk);
		chk("inpos_off", 32'h0, 32'(pif.move_done_flag));
		drop <= 1'b0;
		repeat (4) @(posedge clk);
		chk("inpos_on", 32'h1, 32'(pif.move_done_flag));
		mode <= 1'b0;
	endtask : s_done_mode

	task s_loss;
		@(posedge clk);
		servo <= 1'b0;
		repeat (4) @(posedge clk);
		chk("servo_off", 32'h0, 32'(pif.move_done_flag));
		servo <= 1'b1;
		lost  <= 1'b1;
		@(posedge clk);
		lost  <= 1'b0;
		repeat (4) @(posedge clk);
		chk("homed_lost", 32'h0, 32'(pif.homed_flag));
	endtask : s_loss

	task print_verdict;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict

	// =================================================================
	// sequence and watchdog
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		s_regs();
		s_home_first();
		s_positions();
		s_done_mode();
		s_loss();
		print_verdict();
	end

	initial begin
		#200000;
		mismatches++;
		print_verdict();
	end
endmodule : tb_position_select_start_handshake
